// ---- src/mmo_pkg.sv ----
// constants, types and decode helpers for the memory map option control block
package mmo_pkg;

  // register map: printed offset is a word index, byte address is four times it
  localparam int              APB_ADDR_W    = 18;
  localparam logic [15:0]     OPT_INDEX     = 16'h3fdf;
  localparam logic [17:0]     OPT_ADDR      = {OPT_INDEX, 2'b00};

  // option register layout
  localparam int              OPT_W         = 8;
  localparam int              OPT_LOW_BIT   = 7;
  localparam int              OPT_HIGH_BIT  = 6;
  localparam int              OPT_SENS_BIT  = 1;
  localparam logic            LOW_RESET     = 1'b0;
  localparam logic            HIGH_RESET    = 1'b0;
  localparam logic            SENS_RESET    = 1'b1;

  // cpu address windows
  localparam int              CPU_ADDR_W    = 14;
  localparam logic [13:0]     LOW_WIN_FIRST = 14'h0020;
  localparam logic [13:0]     LOW_WIN_LAST  = 14'h004f;
  localparam logic [13:0]     HIGH_WIN_FIRST = 14'h0100;
  localparam logic [13:0]     HIGH_WIN_LAST = 14'h017f;

  // timing
  localparam int              CLK_MHZ       = 125;
  localparam int              RST_DRIVE_NS  = 1000;
  localparam int              RST_DRIVE_CYC = (RST_DRIVE_NS * CLK_MHZ + 999) / 1000;
  localparam int              CNT_W         = 8;

  typedef enum logic [1:0] {
    MMO_RS_IDLE    = 2'b00,
    MMO_RS_DRIVE   = 2'b01,
    MMO_RS_RELEASE = 2'b10
  } mmo_rst_state_t;

  function automatic logic mmo_in_window(input logic [13:0] addr,
                                         input logic [13:0] first,
                                         input logic [13:0] last);
    mmo_in_window = (addr >= first) && (addr <= last);
  endfunction

endpackage

// ---- src/mmo_ctl_if.sv ----
// control carrier from the option block to its interrupt detector
`timescale 1ns/10ps
`default_nettype none
interface mmo_ctl_if;
  logic core_rst;
  logic level_mode;

  modport src (output core_rst, output level_mode);
  modport snk (input core_rst, input level_mode);
endinterface
`default_nettype wire

// ---- src/mmo_ext_irq.sv ----
// external interrupt detector for the interrupt pin and port B lines
`timescale 1ns/10ps
`default_nettype none
module mmo_ext_irq #(
  parameter int N = 8
) (
  // clock and control
  input  wire logic         clk,
  mmo_ctl_if.snk            ctl,
  // pins and options
  input  wire logic         irq_pin_n,
  input  wire logic [N-1:0] portb_pins,
  input  wire logic [N-1:0] portb_irq_option,
  // interrupt handshake and port B pull-up enables
  input  wire logic         irq_ack,
  output logic              irq_request,
  output logic [N-1:0]      portb_pullup_en
);

  logic [N:0] s1;
  logic [N:0] s2;
  logic [N:0] s3;
  logic [N:0] flt;
  logic [N:0] enable;
  logic [N:0] fall;
  logic       pending;
  logic       next_pending;
  logic       level_low;

  assign enable = {portb_irq_option, 1'b1};

  genvar i;
  generate
    for (i = 0; i <= N; i++)
    begin : g_line
      logic raw;
      assign raw = (i == 0) ? irq_pin_n : portb_pins[(i == 0) ? 0 : i - 1];
      always_ff @(posedge clk)
      begin
        if (ctl.core_rst)
        begin
          s1[i]  <= 1'b1;
          s2[i]  <= 1'b1;
          s3[i]  <= 1'b1;
          flt[i] <= 1'b1;
        end
        else
        begin
          s1[i] <= raw;
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // glitch filter: second and third stages must agree
          if (s2[i] == s3[i])
            flt[i] <= s3[i];
        end
      end
    end
  endgenerate

  logic [N:0] flt_prev;

  always_ff @(posedge clk)
  begin
    if (ctl.core_rst)
      flt_prev <= '1;
    else
      flt_prev <= flt;
  end

  assign fall      = flt_prev & ~flt & enable;
  assign level_low = |(~flt & enable);

  always_comb
  begin
    next_pending = pending;
    if (|fall)
      next_pending = 1'b1;
    else if (irq_ack)
      next_pending = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (ctl.core_rst)
    begin
      pending     <= 1'b0;
      irq_request <= 1'b0;
    end
    else
    begin
      pending     <= next_pending;
      irq_request <= next_pending | (ctl.level_mode & level_low);
    end
  end

  always_ff @(posedge clk)
  begin
    if (ctl.core_rst)
      portb_pullup_en <= '0;
    else
      portb_pullup_en <= portb_irq_option;
  end

  property p_edge_request;
    @(posedge clk) disable iff (ctl.core_rst)
      (|fall) |=> irq_request;
  endproperty
  a_edge_request: assert property (p_edge_request) else $error("edge lost");

  property p_level_request;
    @(posedge clk) disable iff (ctl.core_rst)
      (ctl.level_mode && level_low) |=> irq_request;
  endproperty
  a_level_request: assert property (p_level_request) else $error("level lost");

  property p_edge_only;
    @(posedge clk) disable iff (ctl.core_rst)
      (!ctl.level_mode && !pending && !(|fall)) |=> !irq_request;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("level seen in edge mode");

endmodule
`default_nettype wire

// ---- src/mmo_reset_pin.sv ----
// bidirectional reset pin: filtered input and internal reset stretch drive
`timescale 1ns/10ps
`default_nettype none
module mmo_reset_pin #(
  parameter int DRIVE_CYC = mmo_pkg::RST_DRIVE_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // internal reset source
  input  wire logic internal_reset_req,
  // pin
  input  wire logic reset_pin_in,
  output logic      reset_pin_out,
  output logic      reset_pin_oe,
  // filtered pin level
  output logic      pin_low
);

  logic                        s1;
  logic                        s2;
  logic                        s3;
  logic [mmo_pkg::CNT_W-1:0]   cnt;
  mmo_pkg::mmo_rst_state_t     state;
  logic [mmo_pkg::CNT_W:0]     oe_len;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1      <= 1'b1;
      s2      <= 1'b1;
      s3      <= 1'b1;
      pin_low <= 1'b0;
    end
    else
    begin
      s1 <= reset_pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        pin_low <= ~s3;
    end
  end

  // stretch keeps the pin low long enough for outside parts to see it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= mmo_pkg::MMO_RS_IDLE;
      cnt   <= '0;
    end
    else
    begin
      case (state)
        mmo_pkg::MMO_RS_IDLE:
        begin
          if (internal_reset_req)
          begin
            state <= mmo_pkg::MMO_RS_DRIVE;
            cnt   <= mmo_pkg::CNT_W'(DRIVE_CYC - 1);
          end
        end
        mmo_pkg::MMO_RS_DRIVE:
        begin
          if (cnt == '0)
            state <= mmo_pkg::MMO_RS_RELEASE;
          else
            cnt <= cnt - 1'b1;
        end
        mmo_pkg::MMO_RS_RELEASE:
        begin
          // wait for the pin to read high so one request makes one pulse
          if (!pin_low)
            state <= mmo_pkg::MMO_RS_IDLE;
        end
        default:
          state <= mmo_pkg::MMO_RS_IDLE;
      endcase
    end
  end

  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = (state == mmo_pkg::MMO_RS_DRIVE);

  // drive length counted here, the stretch is too long to unroll
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      oe_len <= '0;
    else if (reset_pin_oe)
      oe_len <= oe_len + 1'b1;
    else
      oe_len <= '0;
  end

  property p_drive_start;
    @(posedge clk) disable iff (!rst_n)
      (state == mmo_pkg::MMO_RS_IDLE && internal_reset_req) |=> reset_pin_oe;
  endproperty
  a_drive_start: assert property (p_drive_start) else $error("reset pin not driven");

  property p_drive_len;
    @(posedge clk) disable iff (!rst_n)
      $fell(reset_pin_oe) |-> (oe_len == DRIVE_CYC);
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("reset pin drive length wrong");

endmodule
`default_nettype wire

// ---- src/mmo_option_ctrl.sv ----
// option register, memory window mapping, interrupt sensitivity and reset control
`timescale 1ns/10ps
`default_nettype none
module mmo_option_ctrl #(
  parameter int PORTB_W   = 8,
  parameter int DRIVE_CYC = mmo_pkg::RST_DRIVE_CYC
) (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [mmo_pkg::APB_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic                                 pready,
  output logic [31:0]                          prdata,
  output logic                                 pslverr,
  // memory window mapping
  input  wire logic [mmo_pkg::CPU_ADDR_W-1:0]  cpu_addr,
  output logic                                 low_window_ram_select,
  output logic                                 high_window_ram_select,
  output logic                                 window_ram_access,
  output logic                                 window_rom_access,
  // external interrupt
  input  wire logic                            irq_pin_n,
  input  wire logic [PORTB_W-1:0]              portb_pins,
  input  wire logic [PORTB_W-1:0]              portb_irq_option,
  input  wire logic                            irq_ack,
  output logic                                 irq_request,
  output logic                                 level_mode,
  output logic [PORTB_W-1:0]                   portb_pullup_en,
  // reset pin and core reset
  input  wire logic                            internal_reset_req,
  input  wire logic                            reset_pin_in,
  output logic                                 reset_pin_out,
  output logic                                 reset_pin_oe,
  output logic                                 core_reset,
  // system clock enable
  output logic                                 sys_clk_en,
  // port directions from the port logic
  input  wire logic [7:0]                      ddr_a,
  input  wire logic [7:0]                      ddr_b,
  input  wire logic [7:0]                      ddr_c,
  input  wire logic [7:0]                      ddr_d,
  output logic [7:0]                           dir_a,
  output logic [7:0]                           dir_b,
  output logic [7:0]                           dir_c,
  output logic [7:0]                           dir_d
);

  mmo_ctl_if ctl ();

  logic                      pin_low;
  logic                      core_rst;
  logic                      sens;
  logic                      locked;
  logic                      setup;
  logic                      access;
  logic                      hit;
  logic                      wr;
  logic                      err_q;
  logic                      div;
  logic                      low_hit;
  logic                      high_hit;
  logic [mmo_pkg::OPT_W-1:0] opt_rd;

  // reset pin and core reset
  mmo_reset_pin #(
    .DRIVE_CYC (DRIVE_CYC)
  ) u_reset_pin (
    .clk                (clk),
    .rst_n              (rst_n),
    .internal_reset_req (internal_reset_req),
    .reset_pin_in       (reset_pin_in),
    .reset_pin_out      (reset_pin_out),
    .reset_pin_oe       (reset_pin_oe),
    .pin_low            (pin_low)
  );

  assign core_rst       = !rst_n || pin_low;
  assign core_reset     = core_rst;
  assign ctl.core_rst   = core_rst;
  assign ctl.level_mode = sens;
  assign level_mode     = sens;

  // apb slave: zero wait, read data captured in the setup cycle
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign hit    = (paddr == mmo_pkg::OPT_ADDR);
  assign wr     = access && pwrite && hit && pstrb[0];
  assign pready = access;

  always_comb
  begin
    opt_rd                        = '0;
    opt_rd[mmo_pkg::OPT_LOW_BIT]  = low_window_ram_select;
    opt_rd[mmo_pkg::OPT_HIGH_BIT] = high_window_ram_select;
    opt_rd[mmo_pkg::OPT_SENS_BIT] = sens;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata <= '0;
      err_q  <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= hit ? {24'h000000, opt_rd} : 32'h00000000;
      err_q  <= !hit;
    end
  end

  assign pslverr = access && err_q;

  // window select bits: writable at any time
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      low_window_ram_select  <= mmo_pkg::LOW_RESET;
      high_window_ram_select <= mmo_pkg::HIGH_RESET;
    end
    else if (wr)
    begin
      low_window_ram_select  <= pwdata[mmo_pkg::OPT_LOW_BIT];
      high_window_ram_select <= pwdata[mmo_pkg::OPT_HIGH_BIT];
    end
  end

  // sensitivity: first write after reset wins, later ones are dropped quietly
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      sens   <= mmo_pkg::SENS_RESET;
      locked <= 1'b0;
    end
    else if (wr)
    begin
      locked <= 1'b1;
      if (!locked)
        sens <= pwdata[mmo_pkg::OPT_SENS_BIT];
    end
  end

  // window decode registered: ram/rom strobes follow the address by one cycle
  assign low_hit  = mmo_pkg::mmo_in_window(cpu_addr, mmo_pkg::LOW_WIN_FIRST,
                                           mmo_pkg::LOW_WIN_LAST);
  assign high_hit = mmo_pkg::mmo_in_window(cpu_addr, mmo_pkg::HIGH_WIN_FIRST,
                                           mmo_pkg::HIGH_WIN_LAST);

  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      window_ram_access <= 1'b0;
      window_rom_access <= 1'b0;
    end
    else
    begin
      window_ram_access <= (low_hit && low_window_ram_select)
                        || (high_hit && high_window_ram_select);
      window_rom_access <= (low_hit && !low_window_ram_select)
                        || (high_hit && !high_window_ram_select);
    end
  end

  // clk is the crystal rate; core logic advances on every second edge
  always_ff @(posedge clk)
  begin
    if (core_rst)
      div <= 1'b0;
    else
      div <= !div;
  end

  assign sys_clk_en = div;

  // port directions forced to input while reset holds
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      dir_a <= '0;
      dir_b <= '0;
      dir_c <= '0;
      dir_d <= '0;
    end
    else
    begin
      dir_a <= ddr_a;
      dir_b <= ddr_b;
      dir_c <= ddr_c;
      dir_d <= ddr_d;
    end
  end

  mmo_ext_irq #(
    .N (PORTB_W)
  ) u_ext_irq (
    .clk              (clk),
    .ctl              (ctl),
    .irq_pin_n        (irq_pin_n),
    .portb_pins       (portb_pins),
    .portb_irq_option (portb_irq_option),
    .irq_ack          (irq_ack),
    .irq_request      (irq_request),
    .portb_pullup_en  (portb_pullup_en)
  );

  property p_low_ram;
    @(posedge clk) disable iff (core_rst)
      (low_hit && low_window_ram_select) |=> (window_ram_access && !window_rom_access);
  endproperty
  a_low_ram: assert property (p_low_ram) else $error("low window not ram");

  property p_high_rom;
    @(posedge clk) disable iff (core_rst)
      (high_hit && !high_window_ram_select) |=> (window_rom_access && !window_ram_access);
  endproperty
  a_high_rom: assert property (p_high_rom) else $error("high window not rom");

  property p_sens_clear;
    @(posedge clk) disable iff (core_rst)
      (wr && !locked && !pwdata[mmo_pkg::OPT_SENS_BIT]) |=> !level_mode;
  endproperty
  a_sens_clear: assert property (p_sens_clear) else $error("edge mode not taken");

  property p_sens_reset;
    @(posedge clk) disable iff (!rst_n)
      core_rst |=> (sens && !locked);
  endproperty
  a_sens_reset: assert property (p_sens_reset) else $error("sensitivity reset wrong");

  property p_sens_locked;
    @(posedge clk) disable iff (core_rst)
      locked |=> $stable(sens);
  endproperty
  a_sens_locked: assert property (p_sens_locked) else $error("locked bit changed");

  property p_read_locked;
    @(posedge clk) disable iff (core_rst)
      (setup && hit && locked) |=> (prdata[mmo_pkg::OPT_SENS_BIT] == sens);
  endproperty
  a_read_locked: assert property (p_read_locked) else $error("locked value not read");

  property p_half_rate;
    @(posedge clk) disable iff (core_rst)
      sys_clk_en |=> !sys_clk_en ##1 sys_clk_en;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("clock enable not half rate");

  property p_dir_reset;
    @(posedge clk) disable iff (!rst_n)
      core_rst |=> (dir_a == 8'h00 && dir_b == 8'h00 && dir_c == 8'h00 && dir_d == 8'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("port not input in reset");

  property p_low_rom;
    @(posedge clk) disable iff (core_rst)
      (low_hit && !low_window_ram_select) |=> (window_rom_access && !window_ram_access);
  endproperty
  a_low_rom: assert property (p_low_rom) else $error("low window not rom");

  property p_high_ram;
    @(posedge clk) disable iff (core_rst)
      (high_hit && high_window_ram_select) |=> (window_ram_access && !window_rom_access);
  endproperty
  a_high_ram: assert property (p_high_ram) else $error("high window not ram");

  property p_no_window;
    @(posedge clk) disable iff (core_rst)
      !(low_hit || high_hit) |=> !(window_ram_access || window_rom_access);
  endproperty
  a_no_window: assert property (p_no_window) else $error("strobe outside windows");

  property p_lock_set;
    @(posedge clk) disable iff (core_rst)
      wr |=> locked;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("write did not lock");

  property p_low_write;
    @(posedge clk) disable iff (core_rst)
      wr |=> (low_window_ram_select == $past(pwdata[mmo_pkg::OPT_LOW_BIT]));
  endproperty
  a_low_write: assert property (p_low_write) else $error("low bit not written");

  property p_high_write;
    @(posedge clk) disable iff (core_rst)
      wr |=> (high_window_ram_select == $past(pwdata[mmo_pkg::OPT_HIGH_BIT]));
  endproperty
  a_high_write: assert property (p_high_write) else $error("high bit not written");

  property p_sens_first;
    @(posedge clk) disable iff (core_rst)
      (wr && !locked) |=> (sens == $past(pwdata[mmo_pkg::OPT_SENS_BIT]));
  endproperty
  a_sens_first: assert property (p_sens_first) else $error("first sensitivity write lost");

endmodule
`default_nettype wire

// ---- test/mmo_option_ctrl_tb.sv ----
// self-checking testbench for the memory map option control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // small drive stretch keeps the reset pin scenario short
  localparam int DRV = 4;
  logic                            clk = 1'b0;
  logic                            rst_n = 1'b0;
  logic                            psel = 1'b0;
  logic                            penable = 1'b0;
  logic                            pwrite = 1'b0;
  logic [mmo_pkg::APB_ADDR_W-1:0]  paddr = '0;
  logic [31:0]                     pwdata = '0;
  logic [3:0]                      pstrb = '0;
  logic [mmo_pkg::CPU_ADDR_W-1:0]  cpu_addr = '0;
  logic                            irq_pin_n = 1'b1;
  logic [7:0]                      portb_pins = 8'hff;
  logic [7:0]                      portb_irq_option = 8'h28;
  logic                            irq_ack = 1'b0;
  logic                            internal_reset_req = 1'b0;
  logic                            ext_pin = 1'b1;
  logic [7:0]                      ddr_a = 8'h00;
  logic [7:0]                      ddr_b = 8'h00;
  logic [7:0]                      ddr_c = 8'h00;
  logic [7:0]                      ddr_d = 8'h00;
  wire logic                       reset_pin_in;
  logic                            pready;
  logic [31:0]                     prdata;
  logic                            pslverr;
  logic                            low_sel;
  logic                            high_sel;
  logic                            win_ram;
  logic                            win_rom;
  logic                            irq_request;
  logic                            level_mode;
  logic [7:0]                      portb_pullup_en;
  logic                            reset_pin_out;
  logic                            reset_pin_oe;
  logic                            core_reset;
  logic                            sys_clk_en;
  logic [7:0]                      dir_a;
  logic [7:0]                      dir_b;
  logic [7:0]                      dir_c;
  logic [7:0]                      dir_d;
  int                              n_mismatch = 0;
  int                              checks_done = 0;
  int                              seed = 72222;
  int                              m_low;
  int                              m_high;
  int                              m_sens;
  int                              m_lock;
  int                              n;
  logic [31:0]                     rd;
  logic [31:0]                     d;
  logic                            err;
  logic                            prev;
  logic [13:0]                     tbl [8] = '{14'h001f, 14'h0020, 14'h004f, 14'h0050,
                                               14'h00ff, 14'h0100, 14'h017f, 14'h0180};

  // pin has a pull-up; device drive wins
  assign reset_pin_in = (reset_pin_oe === 1'b1 && reset_pin_out === 1'b0) ? 1'b0 : ext_pin;

  always #4 clk = ~clk;

  mmo_option_ctrl #(.PORTB_W(8), .DRIVE_CYC(DRV)) i_mmo_option_ctrl (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cpu_addr(cpu_addr), .low_window_ram_select(low_sel),
    .high_window_ram_select(high_sel), .window_ram_access(win_ram),
    .window_rom_access(win_rom), .irq_pin_n(irq_pin_n), .portb_pins(portb_pins),
    .portb_irq_option(portb_irq_option), .irq_ack(irq_ack), .irq_request(irq_request),
    .level_mode(level_mode), .portb_pullup_en(portb_pullup_en),
    .internal_reset_req(internal_reset_req), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .core_reset(core_reset),
    .sys_clk_en(sys_clk_en), .ddr_a(ddr_a), .ddr_b(ddr_b), .ddr_c(ddr_c), .ddr_d(ddr_d),
    .dir_a(dir_a), .dir_b(dir_b), .dir_c(dir_c), .dir_d(dir_d));

  task automatic complete_run;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic model_reset;
    m_low  = 0;
    m_high = 0;
    m_sens = 1;
    m_lock = 0;
  endtask

  function automatic logic [31:0] exp_opt();
    logic [31:0] e;
    e = '0;
    e[mmo_pkg::OPT_LOW_BIT]  = m_low[0];
    e[mmo_pkg::OPT_HIGH_BIT] = m_high[0];
    e[mmo_pkg::OPT_SENS_BIT] = m_sens[0];
    return e;
  endfunction

  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      chk(32'h0, 32'h1);
    // the first accepted write consumes the one sensitivity change
    if (wr && s[0] && a == mmo_pkg::OPT_ADDR)
    begin
      m_low  = wd[mmo_pkg::OPT_LOW_BIT];
      m_high = wd[mmo_pkg::OPT_HIGH_BIT];
      if (m_lock == 0)
        m_sens = wd[mmo_pkg::OPT_SENS_BIT];
      m_lock = 1;
    end
  endtask

  task automatic read_opt;
    apb(1'b0, mmo_pkg::OPT_ADDR, 32'h0, 4'h0, rd, err);
    chk(rd, exp_opt());
    chk1(err, 1'b0);
  endtask

  task automatic write_opt(input logic [31:0] wd);
    apb(1'b1, mmo_pkg::OPT_ADDR, wd, 4'hf, rd, err);
    read_opt();
  endtask

  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq_request !== lvl && n < 12)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic ack_pulse;
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
  endtask

  task automatic wait_core;
    n = 0;
    while (core_reset !== 1'b0 && n < 30)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1(core_reset, 1'b0);
    model_reset();
  endtask

  task automatic win_check;
    logic [13:0] a;
    logic        inl;
    logic        inh;
    for (int i = 0; i < 10; i++)
    begin
      a = (i < 8) ? tbl[i] : 14'($random(seed));
      @(posedge clk);
      cpu_addr <= a;
      @(posedge clk);
      #1;
      inl = (a >= mmo_pkg::LOW_WIN_FIRST) && (a <= mmo_pkg::LOW_WIN_LAST);
      inh = (a >= mmo_pkg::HIGH_WIN_FIRST) && (a <= mmo_pkg::HIGH_WIN_LAST);
      chk1(win_ram, (inl && m_low[0]) || (inh && m_high[0]));
      chk1(win_rom, (inl && !m_low[0]) || (inh && !m_high[0]));
    end
    chk({30'h0, low_sel, high_sel}, {30'h0, m_low[1:0] == 2'd1, m_high[1:0] == 2'd1});
  endtask

  initial
  begin
    #40000;
    $display("BAD %0t watchdog expired", $time);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    model_reset();
    @(posedge clk);
    ddr_a <= 8'($random(seed)) | 8'h01;
    ddr_b <= 8'($random(seed)) | 8'h02;
    ddr_c <= 8'($random(seed)) | 8'h04;
    ddr_d <= 8'($random(seed)) | 8'h08;
    repeat (5) @(posedge clk);
    #1;
    chk({dir_d, dir_c, dir_b, dir_a}, 32'h0);
    chk1(level_mode, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    read_opt();
    chk({24'h0, portb_pullup_en}, {24'h0, portb_irq_option});
    chk({dir_d, dir_c, dir_b, dir_a}, {ddr_d, ddr_c, ddr_b, ddr_a});
    #1;
    prev = sys_clk_en;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      chk1(sys_clk_en, ~prev);
      prev = sys_clk_en;
    end
    // level mode from reset: a line without the option must stay quiet
    @(posedge clk);
    portb_pins <= 8'hfe;
    repeat (10) @(posedge clk);
    #1;
    chk1(irq_request, 1'b0);
    @(posedge clk);
    portb_pins <= 8'hf6;
    wait_irq(1'b1);
    chk1(irq_request, 1'b1);
    ack_pulse();
    repeat (4) @(posedge clk);
    #1;
    chk1(irq_request, 1'b1);
    @(posedge clk);
    portb_pins <= 8'hff;
    ack_pulse();
    wait_irq(1'b0);
    chk1(irq_request, 1'b0);
    d = $random(seed);
    d[mmo_pkg::OPT_SENS_BIT] = 1'b0;
    write_opt(d);
    chk1(level_mode, 1'b0);
    d = $random(seed);
    d[mmo_pkg::OPT_SENS_BIT] = 1'b1;
    write_opt(d);
    win_check();
    write_opt(~d);
    win_check();
    // edge-only: a held low level gives one request only
    @(posedge clk);
    irq_pin_n <= 1'b0;
    wait_irq(1'b1);
    chk1(irq_request, 1'b1);
    ack_pulse();
    repeat (8) @(posedge clk);
    #1;
    chk1(irq_request, 1'b0);
    @(posedge clk);
    irq_pin_n <= 1'b1;
    apb(1'b1, mmo_pkg::OPT_ADDR, ~exp_opt(), 4'he, rd, err);
    read_opt();
    apb(1'b1, mmo_pkg::OPT_ADDR ^ 18'h4, 32'hff, 4'hf, rd, err);
    chk1(err, 1'b1);
    apb(1'b0, mmo_pkg::OPT_ADDR ^ 18'h4, 32'h0, 4'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    read_opt();
    // internal reset drives the pin for the stretch, which resets the core too
    @(posedge clk);
    internal_reset_req <= 1'b1;
    @(posedge clk);
    internal_reset_req <= 1'b0;
    n = 0;
    while (reset_pin_oe !== 1'b1 && n < 5)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // the driven cycle seen on entry counts as the first one
    n = 1;
    while (reset_pin_oe === 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n), 32'(DRV));
    wait_core();
    read_opt();
    write_opt(32'hc0);
    @(posedge clk);
    ext_pin <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk1(core_reset, 1'b1);
    chk({dir_d, dir_c, dir_b, dir_a}, 32'h0);
    chk1(level_mode, 1'b1);
    @(posedge clk);
    ext_pin <= 1'b1;
    wait_core();
    read_opt();
    complete_run();
  end
endmodule
`default_nettype wire
